// >>> common/nvm_defines.svh
`ifndef NVM_DEFINES_SVH
`define NVM_DEFINES_SVH

// register byte offsets
`define NVM_OFF_DATA_LOW     8'h00
`define NVM_OFF_DATA_HIGH    8'h04
`define NVM_OFF_ADDR_LOW     8'h08
`define NVM_OFF_ADDR_HIGH    8'h0c
`define NVM_OFF_CONTROL      8'h10
`define NVM_OFF_UNLOCK       8'h14
`define NVM_OFF_IRQ          8'h18

// control field positions
`define NVM_BIT_PROGRAM      7
`define NVM_BIT_CONFIG       6
`define NVM_BIT_LATCH_ONLY   5
`define NVM_BIT_ERASE        4
`define NVM_BIT_ERROR        3
`define NVM_BIT_ENABLE       2
`define NVM_BIT_WRITE        1
`define NVM_BIT_READ         0

// irq register field positions
`define NVM_BIT_DONE_FLAG    0
`define NVM_BIT_DONE_ENABLE  1

// unlock pattern
`define NVM_UNLOCK_FIRST     8'h55
`define NVM_UNLOCK_SECOND    8'haa

// config space map, low 15 address bits
`define NVM_CFG_USER_ID_LAST 15'h0003
`define NVM_CFG_DEVICE_ID    15'h0006
`define NVM_CFG_WORD_FIRST   15'h0007
`define NVM_CFG_WORD_LAST    15'h0008

// reset values
`define NVM_RESET_BYTE       8'h00
`define NVM_RESET_WORD       14'h0000

// self-timed operation length, cycles of aclk
`define NVM_OP_CYCLES        16'd100
`define NVM_LATCH_LAST       3'd7

`endif

// >>> common/nvm_pkg.sv
package nvm_pkg;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_READ  = 5'b00010,
        ST_ERASE = 5'b00100,
        ST_FLUSH = 5'b01000,
        ST_WAIT  = 5'b10000
    } state_e;

    typedef enum logic [1:0] {
        SPACE_EEPROM = 2'b00,
        SPACE_FLASH  = 2'b01,
        SPACE_CONFIG = 2'b10
    } space_e;

    typedef enum logic [1:0] {
        UNLOCK_NONE  = 2'b00,
        UNLOCK_FIRST = 2'b01,
        UNLOCK_ARMED = 2'b10
    } unlock_e;

endpackage

// >>> core/nvm_eeprom_flash_control.sv
// How it works
// - data low byte holds eeprom byte or low eight bits of a word.
// - data high holds word bits 13:8 in bits 5:0, top two read zero.
// - address high holds seven address bits, its top bit reads one.
// - program select bit set goes to flash, clear goes to eeprom.
// - config select bit set targets user id, device id and config words.
// - flash or config with latch-only set: write strobe only loads latches.
// - latch-only clear: load latch then program every latched word.
// - eeprom selected ignores latch-only, each strobe writes eeprom directly.
// - flash erase select makes strobe erase; hardware clears bit afterwards.
// - eeprom ignores erase select; each strobe erases then writes.
// - error flag set on refused strobe; clear means normal end.
// - with program enable clear, no erase or program is started.
// - write strobe starts timed operation, hardware clears it; zero writes ignored.
// - read strobe loads data pair in one cycle then clears itself.
// - unlock port is write-only, stores nothing, only tracks the sequence.
// - config space: user ids read/write, device id and config words read only.
// - config read outside the readable locations clears both data registers.
`timescale 1ns/1ns
`default_nettype none
`include "nvm_defines.svh"

module nvm_eeprom_flash_control
    import nvm_pkg::*;
#(
    parameter logic [15:0] OP_CYCLES = `NVM_OP_CYCLES
)
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output var  logic        awready,
    // axi4-lite write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output var  logic        wready,
    // axi4-lite write response
    output var  logic [1:0]  bresp,
    output var  logic        bvalid,
    input  wire logic        bready,
    // axi4-lite read address
    input  wire logic [7:0]  araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output var  logic        arready,
    // axi4-lite read data
    output var  logic [31:0] rdata,
    output var  logic [1:0]  rresp,
    output var  logic        rvalid,
    input  wire logic        rready,
    // nonvolatile array side
    output var  logic        mem_read_en,
    output var  logic        mem_erase_en,
    output var  logic        mem_write_en,
    output var  logic [1:0]  mem_space,
    output var  logic [14:0] mem_addr,
    output var  logic [13:0] mem_wdata,
    input  wire logic [13:0] mem_rdata,
    // completion interrupt
    output var  logic        nvm_done_irq
);

    // register state
    logic [7:0]  nvm_data_low;
    logic [5:0]  nvm_data_high;
    logic [7:0]  nvm_address_low;
    logic [6:0]  nvm_address_high;
    logic [5:0]  ctl_mode;
    logic        sequence_error_flag;
    logic        write_strobe;
    logic        read_strobe;
    logic        nvm_done_flag;
    logic        nvm_done_irq_enable;
    unlock_e     unlock_stage;
    state_e      state;
    logic [15:0] timer;
    logic [2:0]  flush_idx;
    logic        op_is_erase;
    logic        read_cfg_ok;
    logic [13:0] write_latch [0:7];

    // ctl_mode holds bits 7:4 and 2 of the control register; ctl_mode[1] is unused
    wire program_space_select = ctl_mode[5];
    wire config_space_select  = ctl_mode[4];
    wire program_enable       = ctl_mode[0];

    // write channel: address and data taken together in one cycle
    wire       w_fire   = awready && awvalid && wvalid;
    wire       lane0    = wstrb[0];
    wire [7:0] wbyte    = wdata[7:0];
    wire       busy     = (state != ST_IDLE);
    wire       hit_dl   = w_fire && lane0 && awaddr == `NVM_OFF_DATA_LOW;
    wire       hit_dh   = w_fire && lane0 && awaddr == `NVM_OFF_DATA_HIGH;
    wire       hit_al   = w_fire && lane0 && awaddr == `NVM_OFF_ADDR_LOW;
    wire       hit_ah   = w_fire && lane0 && awaddr == `NVM_OFF_ADDR_HIGH;
    wire       hit_ctl  = w_fire && lane0 && awaddr == `NVM_OFF_CONTROL;
    wire       hit_unl  = w_fire && lane0 && awaddr == `NVM_OFF_UNLOCK;
    wire       hit_irq  = w_fire && lane0 && awaddr == `NVM_OFF_IRQ;
    wire       w_mapped = awaddr == `NVM_OFF_DATA_LOW
                       || awaddr == `NVM_OFF_DATA_HIGH
                       || awaddr == `NVM_OFF_ADDR_LOW
                       || awaddr == `NVM_OFF_ADDR_HIGH
                       || awaddr == `NVM_OFF_CONTROL
                       || awaddr == `NVM_OFF_UNLOCK
                       || awaddr == `NVM_OFF_IRQ;

    // while an operation runs the data, address and control
    // registers are frozen, as the core would be halted
    wire       reg_wr_ok = !busy;

    // full address and config space map
    wire [14:0] full_addr = {nvm_address_high, nvm_address_low};
    wire cfg_writable = full_addr <= `NVM_CFG_USER_ID_LAST;
    wire cfg_readable = cfg_writable
                     || full_addr == `NVM_CFG_DEVICE_ID
                     || (full_addr >= `NVM_CFG_WORD_FIRST
                         && full_addr <= `NVM_CFG_WORD_LAST);

    // control write: the written mode bits govern the strobe
    wire new_program = wdata[`NVM_BIT_PROGRAM];
    wire new_config  = wdata[`NVM_BIT_CONFIG];
    wire new_latch   = wdata[`NVM_BIT_LATCH_ONLY];
    wire new_erase   = wdata[`NVM_BIT_ERASE];
    wire new_enable  = wdata[`NVM_BIT_ENABLE];
    wire new_flash   = new_program || new_config;
    wire [1:0] new_space = new_config  ? SPACE_CONFIG
                         : new_program ? SPACE_FLASH
                         : SPACE_EEPROM;

    // a zero written to a strobe bit does nothing
    wire wr_attempt = hit_ctl && reg_wr_ok && wdata[`NVM_BIT_WRITE];
    wire wr_accept  = wr_attempt
                   && unlock_stage == UNLOCK_ARMED
                   && new_enable
                   && (!new_config || cfg_writable);
    wire wr_refused = wr_attempt && !wr_accept;
    wire rd_attempt = hit_ctl && reg_wr_ok && wdata[`NVM_BIT_READ]
                   && !wr_attempt;

    // strobe kind on acceptance
    wire latch_load  = wr_accept && new_flash && !new_erase;
    wire start_latch = latch_load && new_latch;
    wire start_flush = latch_load && !new_latch;
    wire start_ferase = wr_accept && new_flash && new_erase;
    wire start_eeprom = wr_accept && !new_flash;
    wire timer_done   = (timer == 16'd0);
    wire op_finish    = state == ST_WAIT && timer_done;

    // read channel decode
    wire ar_fire = arready && arvalid;
    wire [7:0] ctl_read = {ctl_mode[5:2], sequence_error_flag,
                           ctl_mode[0], write_strobe, read_strobe};
    wire [7:0] rd_byte =
        araddr == `NVM_OFF_DATA_LOW  ? nvm_data_low
      : araddr == `NVM_OFF_DATA_HIGH ? {2'b00, nvm_data_high}
      : araddr == `NVM_OFF_ADDR_LOW  ? nvm_address_low
      : araddr == `NVM_OFF_ADDR_HIGH ? {1'b1, nvm_address_high}
      : araddr == `NVM_OFF_CONTROL   ? ctl_read
      : araddr == `NVM_OFF_IRQ       ? {6'h00, nvm_done_irq_enable,
                                        nvm_done_flag}
      : 8'h00; // unlock port has no storage
    wire w_mapped_rd = araddr == `NVM_OFF_DATA_LOW
                    || araddr == `NVM_OFF_DATA_HIGH
                    || araddr == `NVM_OFF_ADDR_LOW
                    || araddr == `NVM_OFF_ADDR_HIGH
                    || araddr == `NVM_OFF_CONTROL
                    || araddr == `NVM_OFF_UNLOCK
                    || araddr == `NVM_OFF_IRQ;
    wire r_mapped = w_mapped_rd;

    // next values for flags; hardware set wins over software clear
    wire next_error = wr_refused ? 1'b1
                    : (hit_ctl && reg_wr_ok) ? wdata[`NVM_BIT_ERROR]
                    : op_finish ? 1'b0
                    : sequence_error_flag;
    wire next_done  = op_finish ? 1'b1
                    : (hit_irq && wdata[`NVM_BIT_DONE_FLAG]) ? 1'b0
                    : nvm_done_flag;

    // read data is taken in the same cycle as the array read pulse
    wire [13:0] fetched = (mem_space == SPACE_CONFIG && !read_cfg_ok)
                        ? 14'h0000 : mem_rdata;

    // axi write handshake; both readies rise together
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= 2'b00;
        end
        else
        begin
            awready <= !awready && !bvalid && awvalid && wvalid;
            wready  <= !awready && !bvalid && awvalid && wvalid;
            if (w_fire)
            begin
                bvalid <= 1'b1;
                bresp  <= w_mapped ? 2'b00 : 2'b10;
            end
            else if (bready)
                bvalid <= 1'b0;
        end
    end

    // axi read handshake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= 2'b00;
        end
        else
        begin
            arready <= !arready && !rvalid && arvalid;
            if (ar_fire)
            begin
                rvalid <= 1'b1;
                rdata  <= {24'h000000, rd_byte};
                rresp  <= r_mapped ? 2'b00 : 2'b10;
            end
            else if (rready)
                rvalid <= 1'b0;
        end
    end

    // unlock tracker: any other write between breaks the sequence
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            unlock_stage <= UNLOCK_NONE;
        else if (hit_unl && wbyte == `NVM_UNLOCK_FIRST)
            unlock_stage <= UNLOCK_FIRST;
        else if (hit_unl && wbyte == `NVM_UNLOCK_SECOND
                 && unlock_stage == UNLOCK_FIRST)
            unlock_stage <= UNLOCK_ARMED;
        else if (w_fire)
            unlock_stage <= UNLOCK_NONE;
    end

    // address registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            nvm_address_low  <= `NVM_RESET_BYTE;
            nvm_address_high <= 7'h00;
        end
        else
        begin
            if (hit_al && reg_wr_ok)
                nvm_address_low <= wbyte;
            if (hit_ah && reg_wr_ok)
                nvm_address_high <= wbyte[6:0];
        end
    end

    // data pair: software writes or array reads
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            nvm_data_low  <= `NVM_RESET_BYTE;
            nvm_data_high <= 6'h00;
        end
        else if (state == ST_READ)
        begin
            nvm_data_low  <= fetched[7:0];
            nvm_data_high <= fetched[13:8];
        end
        else
        begin
            if (hit_dl && reg_wr_ok)
                nvm_data_low <= wbyte;
            if (hit_dh && reg_wr_ok)
                nvm_data_high <= wbyte[5:0];
        end
    end

    // write latches for one eight-word row
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_latch
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    write_latch[gi] <= `NVM_RESET_WORD;
                else if (latch_load && nvm_address_low[2:0] == gi)
                    write_latch[gi] <= {nvm_data_high, nvm_data_low};
            end
        end
    endgenerate

    // control register and flags
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctl_mode            <= 6'h00;
            sequence_error_flag <= 1'b0;
            nvm_done_flag       <= 1'b0;
            nvm_done_irq_enable <= 1'b0;
            nvm_done_irq        <= 1'b0;
        end
        else
        begin
            if (hit_ctl && reg_wr_ok)
            begin
                ctl_mode[5:2] <= wdata[7:4];
                ctl_mode[0]   <= new_enable;
            end
            else if (op_finish && op_is_erase)
                ctl_mode[2] <= 1'b0;
            sequence_error_flag <= next_error;
            nvm_done_flag       <= next_done;
            if (hit_irq)
                nvm_done_irq_enable <= wdata[`NVM_BIT_DONE_ENABLE];
            nvm_done_irq <= next_done && nvm_done_irq_enable;
        end
    end

    // operation sequencer and array strobes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state        <= ST_IDLE;
            timer        <= 16'd0;
            flush_idx    <= 3'd0;
            op_is_erase  <= 1'b0;
            read_cfg_ok  <= 1'b0;
            write_strobe <= 1'b0;
            read_strobe  <= 1'b0;
            mem_read_en  <= 1'b0;
            mem_erase_en <= 1'b0;
            mem_write_en <= 1'b0;
            mem_space    <= SPACE_EEPROM;
            mem_addr     <= 15'h0000;
            mem_wdata    <= `NVM_RESET_WORD;
        end
        else
        begin
            mem_read_en  <= 1'b0;
            mem_erase_en <= 1'b0;
            mem_write_en <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    mem_space <= new_space;
                    if (rd_attempt)
                    begin
                        state       <= ST_READ;
                        read_strobe <= 1'b1;
                        read_cfg_ok <= cfg_readable;
                        mem_read_en <= 1'b1;
                        mem_addr    <= full_addr;
                    end
                    else if (start_flush)
                    begin
                        state        <= ST_FLUSH;
                        write_strobe <= 1'b1;
                        op_is_erase  <= 1'b0;
                        flush_idx    <= 3'd0;
                    end
                    else if (start_ferase)
                    begin
                        state        <= ST_WAIT;
                        write_strobe <= 1'b1;
                        op_is_erase  <= 1'b1;
                        timer        <= OP_CYCLES;
                        mem_erase_en <= 1'b1;
                        mem_addr     <= {full_addr[14:3], 3'd0};
                    end
                    else if (start_eeprom)
                    begin
                        state        <= ST_ERASE;
                        write_strobe <= 1'b1;
                        op_is_erase  <= 1'b0;
                        timer        <= OP_CYCLES;
                        mem_erase_en <= 1'b1;
                        mem_addr     <= full_addr;
                        mem_wdata    <= {6'h00, nvm_data_low};
                    end
                end
                ST_READ:
                begin
                    state       <= ST_IDLE;
                    read_strobe <= 1'b0;
                end
                ST_ERASE:
                begin
                    timer <= timer - 16'd1;
                    if (timer_done)
                    begin
                        state        <= ST_WAIT;
                        timer        <= OP_CYCLES;
                        mem_write_en <= 1'b1;
                    end
                end
                ST_FLUSH:
                begin
                    mem_write_en <= 1'b1;
                    mem_addr     <= {full_addr[14:3], flush_idx};
                    mem_wdata    <= write_latch[flush_idx];
                    flush_idx    <= flush_idx + 3'd1;
                    if (flush_idx == `NVM_LATCH_LAST)
                    begin
                        state <= ST_WAIT;
                        timer <= OP_CYCLES;
                    end
                end
                ST_WAIT:
                begin
                    timer <= timer - 16'd1;
                    if (timer_done)
                    begin
                        state        <= ST_IDLE;
                        write_strobe <= 1'b0;
                    end
                end
                default:
                begin
                    state        <= ST_IDLE;
                    write_strobe <= 1'b0;
                    read_strobe  <= 1'b0;
                end
            endcase
        end
    end

    // protection bits carry no meaning in this block
    wire unused_ok = &{1'b0, awprot, arprot, wdata[31:8], wstrb[3:1],
                       program_space_select, config_space_select,
                       program_enable, start_latch, ctl_mode[1]};

endmodule

`default_nettype wire

// >>> testbench/nvm_properties.sv
`timescale 1ns/1ns
`default_nettype none
module nvm_properties #(
    parameter logic [15:0] OP_CYCLES = 16'd100
)
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        awready,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // array side
    input wire logic        mem_read_en,
    input wire logic        mem_erase_en,
    input wire logic        mem_write_en,
    input wire logic [1:0]  mem_space
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ee_erase;
        mem_erase_en && mem_space == 2'b00;
    endsequence
    // write must wait out the erase time, never share its cycle
    sequence ee_write_later;
        !mem_write_en [*3] ##[1:300] mem_write_en;
    endsequence
    take_pair_a: assert property (awready |-> wready)
        else $error("address taken without data");
    write_answer_a: assert property (awready |=> bvalid)
        else $error("no write response");
    bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    read_answer_a: assert property (arready |=> rvalid)
        else $error("no read data");
    rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    rdata_width_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    read_pulse_a: assert property (mem_read_en |=> !mem_read_en)
        else $error("array read longer than one cycle");
    erase_write_a: assert property (ee_erase |=> ee_write_later)
        else $error("eeprom erase not followed by write");
endmodule
bind nvm_eeprom_flash_control nvm_properties #(.OP_CYCLES(OP_CYCLES))
    nvm_properties_inst (
    .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arready(arready), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .mem_read_en(mem_read_en),
    .mem_erase_en(mem_erase_en), .mem_write_en(mem_write_en),
    .mem_space(mem_space));
`default_nettype wire

// >>> testbench/nvm_array_model.sv
`timescale 1ns/1ns
`default_nettype none
module nvm_array_model (
    // clock
    input  wire logic        aclk,
    // array requests
    input  wire logic        mem_read_en,
    input  wire logic        mem_erase_en,
    input  wire logic        mem_write_en,
    input  wire logic [1:0]  mem_space,
    input  wire logic [14:0] mem_addr,
    input  wire logic [13:0] mem_wdata,
    output var  logic [13:0] mem_rdata
);
    logic [13:0] cells [64];
    logic [5:0]  idx;
    assign idx = {mem_space, mem_addr[3:0]};
    // outside a read the bus shows the inverse, never the stored word
    assign mem_rdata = mem_read_en ? cells[idx] : ~cells[idx];
    initial
    begin
        for (int i = 0; i < 64; i++)
            cells[i] = 14'h1000 | 14'(i);
    end
    always @(posedge aclk)
    begin
        if (mem_erase_en && mem_space == 2'b00)
            cells[idx] <= 14'h3fff;
        else if (mem_erase_en)
            for (int j = 0; j < 8; j++)
                cells[{idx[5:3], 3'(j)}] <= 14'h3fff;
        if (mem_write_en)
            cells[idx] <= mem_wdata;
    end
endmodule
`default_nettype wire

// >>> testbench/nvm_eeprom_flash_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module nvm_eeprom_flash_control_tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, nvm_done_irq;
    logic        mem_read_en, mem_erase_en, mem_write_en;
    logic [7:0]  awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic [3:0]  wstrb;
    logic [31:0] wdata, rdata, rd_val;
    logic [1:0]  bresp, rresp, rd_resp, wr_resp, mem_space;
    logic [14:0] mem_addr;
    logic [13:0] mem_wdata, mem_rdata;
    int          num_errors = 0;
    int          n_compared = 0;

    nvm_eeprom_flash_control #(.OP_CYCLES(16'd4))
        nvm_eeprom_flash_control_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .mem_read_en(mem_read_en),
        .mem_erase_en(mem_erase_en), .mem_write_en(mem_write_en),
        .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .nvm_done_irq(nvm_done_irq));
    nvm_array_model nvm_array_model_inst (
        .aclk(aclk), .mem_read_en(mem_read_en), .mem_erase_en(mem_erase_en),
        .mem_write_en(mem_write_en), .mem_space(mem_space),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        @(posedge aclk);
        bready  <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        wr_resp = bresp;
        bready  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        @(posedge aclk);
        rready  <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        rd_val  = rdata;
        rd_resp = rresp;
        rready  <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk($sformatf("reg %h", a), {24'h0, e}, rd_val);
    endtask

    task automatic unl(input logic [7:0] c);
        int n;
        n = 0;
        wr(8'h14, 8'h55);
        wr(8'h14, 8'haa);
        wr(8'h10, c);
        do
        begin
            rd(8'h10);
            n++;
        end
        while (rd_val[1] === 1'b1 && n < 60);
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // about thirty-five times the expected run
    initial
    begin
        #200000;
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        {awprot, arprot} = 6'h00;
        wstrb = 4'h1;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(8'h0c, 8'h80);
        rdc(8'h10, 8'h00);
        wr(8'h14, 8'h55);
        rdc(8'h14, 8'h00);
        rd(8'h1c);
        chk("read resp", 32'h2, {30'h0, rd_resp});
        wr(8'h1c, 8'h00);
        chk("write resp", 32'h2, {30'h0, wr_resp});
        $display("test 1 done");
        wr(8'h04, 8'hff);
        chk("write resp", 32'h0, {30'h0, wr_resp});
        rdc(8'h04, 8'h3f);
        wr(8'h0c, 8'h05);
        rdc(8'h0c, 8'h85);
        wr(8'h0c, 8'h00);
        wr(8'h10, 8'h06);
        rdc(8'h10, 8'h0c);
        unl(8'h02);
        rdc(8'h10, 8'h08);
        $display("test 2 done");
        wr(8'h00, 8'ha5);
        wr(8'h08, 8'h03);
        unl(8'h06);
        rdc(8'h10, 8'h04);
        rdc(8'h18, 8'h01);
        wr(8'h00, 8'h00);
        wr(8'h10, 8'h01);
        rdc(8'h00, 8'ha5);
        rdc(8'h10, 8'h00);
        $display("test 3 done");
        wr(8'h08, 8'h05);
        wr(8'h10, 8'h41);
        rdc(8'h00, 8'h00);
        rdc(8'h04, 8'h00);
        wr(8'h08, 8'h06);
        wr(8'h10, 8'h41);
        rdc(8'h00, 8'h26);
        rdc(8'h04, 8'h10);
        $display("test 4 done");
        wr(8'h18, 8'h03);
        wr(8'h00, 8'h34);
        wr(8'h04, 8'h12);
        wr(8'h08, 8'h02);
        unl(8'ha6);
        chk("irq", 32'h0, {31'h0, nvm_done_irq});
        wr(8'h08, 8'h03);
        unl(8'h86);
        chk("irq", 32'h1, {31'h0, nvm_done_irq});
        wr(8'h08, 8'h02);
        wr(8'h10, 8'h81);
        rdc(8'h00, 8'h34);
        rdc(8'h04, 8'h12);
        unl(8'h96);
        rdc(8'h10, 8'h84);
        wr(8'h10, 8'h81);
        rdc(8'h00, 8'hff);
        $display("test 5 done");
        report_and_stop();
    end
endmodule
`default_nettype wire
